// ### design/high_side_switch_control.sv
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
module high_side_switch_control #(
   parameter int TIMER_PERIOD = hs_switch_pkg::TIMER_CYC
) (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // AHB-Lite slave
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic [31:0]                       hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   // Chip mode
   input  wire hs_switch_pkg::chip_mode_t    chip_mode,
   // Analog sense
   input  wire logic                         supply_over,
   input  wire logic                         supply_under,
   input  wire logic [3:0]                   load_over_current,
   input  wire logic [3:0]                   load_open,
   // Switch drive
   output logic [3:0]                        switched_output
);
   import hs_switch_pkg::*;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [2:0]  code [NUM_OUT];
   logic [7:0]  duty_setting_gen_1;
   logic [7:0]  duty_setting_gen_2;
   logic [1:0]  generator_rate_select;
   logic        overvoltage_shutdown_select;
   logic        undervoltage_shutdown_select;
   logic        supply_fault_recovery;
   logic        switch_supply_over_flag;
   logic        switch_supply_under_flag;
   logic [3:0]  overcurrent_status_reg;
   logic [3:0]  open_load_status_reg;
   logic [3:0]  timer_duty;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic        dp_write;
   logic        dp_read;
   logic [11:0] dp_addr;
   logic        cfg_allowed;
   logic        wr;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign cfg_allowed = (chip_mode == MODE_NORMAL);
   assign wr = dp_write;

   always_ff @(posedge clk) begin
      if (rst) begin
         dp_write <= 1'b0;
      end else if (hready) begin
         dp_write <= hsel && htrans[1] && hwrite;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dp_read <= 1'b0;
      end else if (hready) begin
         dp_read <= hsel && htrans[1] && !hwrite;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dp_addr <= 12'h000;
      end else if (hready) begin
         dp_addr <= haddr[11:0];
      end
   end

   // ----------------------------------------------------------------
   // Supply fault handling
   // ----------------------------------------------------------------
   logic ov_active;
   logic uv_active;
   logic fault;
   logic fault_d;
   logic fault_end;
   logic mode_off;
   logic mode_off_d;

   assign ov_active = supply_over && !overvoltage_shutdown_select;
   assign uv_active = supply_under && !undervoltage_shutdown_select;
   assign fault = ov_active || uv_active;
   assign fault_end = fault_d && !fault;
   assign mode_off = (chip_mode == MODE_RESTART)
                  || (chip_mode == MODE_FAILSAFE);

   always_ff @(posedge clk) begin
      if (rst) begin
         fault_d <= 1'b0;
      end else begin
         fault_d <= fault;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_off_d <= 1'b0;
      end else begin
         mode_off_d <= mode_off;
      end
   end

   // ----------------------------------------------------------------
   // Timers and generators
   // ----------------------------------------------------------------
   logic [31:0] tmr_cnt;
   logic        tmr1;
   logic        tmr2;
   logic        pwm1;
   logic        pwm2;

   always_ff @(posedge clk) begin
      if (rst || tmr_cnt == 32'(TIMER_PERIOD - 1)) begin
         tmr_cnt <= 32'h0;
      end else begin
         tmr_cnt <= tmr_cnt + 32'h1;
      end
   end

   // Timer 1 on first half, timer 2 on chosen fraction of period
   assign tmr1 = tmr_cnt < 32'(TIMER_PERIOD / 2);
   assign tmr2 = tmr_cnt < 32'(TIMER_PERIOD / 16)
                         * {28'h0, timer_duty};

   pwm_gen u_pwm1 (
      .clk      (clk),
      .rst      (rst),
      .duty     (duty_setting_gen_1),
      .rate_400 (generator_rate_select[0]),
      .pwm_out  (pwm1)
   );

   pwm_gen u_pwm2 (
      .clk      (clk),
      .rst      (rst),
      .duty     (duty_setting_gen_2),
      .rate_400 (generator_rate_select[1]),
      .pwm_out  (pwm2)
   );

   // ----------------------------------------------------------------
   // Per-output logic
   // ----------------------------------------------------------------
   logic [3:0] src_on;
   logic [3:0] trip;
   logic [3:0] cfg_wr;

   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++) begin : g_out
         always_comb begin
            case (switch_code_t'(code[g]))
               CODE_ON:   src_on[g] = 1'b1;
               CODE_TMR1: src_on[g] = tmr1;
               CODE_TMR2: src_on[g] = tmr2;
               CODE_PWM1: src_on[g] = pwm1;
               CODE_PWM2: src_on[g] = pwm2;
               default:   src_on[g] = 1'b0;
            endcase
         end

         assign cfg_wr[g] = wr && cfg_allowed
                         && (dp_addr == (g < 2 ? ADDR_CFG_A : ADDR_CFG_B));

         oc_filter u_oc (
            .clk    (clk),
            .rst    (rst),
            .active (switched_output[g]),
            .over   (load_over_current[g]),
            .trip   (trip[g])
         );

         always_ff @(posedge clk) begin
            if (rst) begin
               code[g] <= CODE_OFF;
            end else if (trip[g]) begin
               code[g] <= CODE_OFF;
            end else if (fault_end && !supply_fault_recovery) begin
               code[g] <= CODE_OFF;
            end else if (mode_off && !mode_off_d) begin
               code[g] <= CODE_OFF;
            end else if (cfg_wr[g]) begin
               // Write takes effect at once
               code[g] <= hwdata[(g % 2) * 4 +: 3];
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               switched_output[g] <= 1'b0;
            end else begin
               // Off during fault; resumes after only with recovery bit set
               // Held off one cycle more while codes clear
               switched_output[g] <= src_on[g] && !fault && !fault_d
                                  && !mode_off && !trip[g];
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               overcurrent_status_reg[g] <= 1'b0;
            end else if (trip[g]) begin
               overcurrent_status_reg[g] <= 1'b1;
            end else if (wr && dp_addr == ADDR_OC_STAT && hwdata[g]) begin
               overcurrent_status_reg[g] <= 1'b0;
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               open_load_status_reg[g] <= 1'b0;
            end else if (switched_output[g] && load_open[g]) begin
               open_load_status_reg[g] <= 1'b1;
            end else if (wr && dp_addr == ADDR_OL_STAT && hwdata[g]) begin
               open_load_status_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic cfg_reg_wr;
   assign cfg_reg_wr = wr && cfg_allowed;

   always_ff @(posedge clk) begin
      if (rst) begin
         duty_setting_gen_1 <= 8'h00;
      end else if (cfg_reg_wr && dp_addr == ADDR_DUTY_1) begin
         duty_setting_gen_1 <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         duty_setting_gen_2 <= 8'h00;
      end else if (cfg_reg_wr && dp_addr == ADDR_DUTY_2) begin
         duty_setting_gen_2 <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         generator_rate_select <= 2'h0;
      end else if (cfg_reg_wr && dp_addr == ADDR_RATE) begin
         generator_rate_select <= hwdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         timer_duty <= 4'h0;
      end else if (cfg_reg_wr && dp_addr == ADDR_TIMER) begin
         timer_duty <= hwdata[3:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         overvoltage_shutdown_select <= 1'b0;
      end else if (cfg_reg_wr && dp_addr == ADDR_SUPPLY) begin
         overvoltage_shutdown_select <= hwdata[SUP_OV_SEL_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         undervoltage_shutdown_select <= 1'b0;
      end else if (cfg_reg_wr && dp_addr == ADDR_SUPPLY) begin
         undervoltage_shutdown_select <= hwdata[SUP_UV_SEL_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         supply_fault_recovery <= 1'b0;
      end else if (cfg_reg_wr && dp_addr == ADDR_SUPPLY) begin
         supply_fault_recovery <= hwdata[SUP_REC_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Supply status flags
   // ----------------------------------------------------------------
   logic clr_sup;
   assign clr_sup = wr && dp_addr == ADDR_SUPPLY;

   always_ff @(posedge clk) begin
      if (rst) begin
         switch_supply_over_flag <= 1'b0;
      end else if (supply_over) begin
         switch_supply_over_flag <= 1'b1;
      end else if (clr_sup && hwdata[SUP_OV_FLAG]) begin
         switch_supply_over_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         switch_supply_under_flag <= 1'b0;
      end else if (supply_under) begin
         switch_supply_under_flag <= 1'b1;
      end else if (clr_sup && hwdata[SUP_UV_FLAG]) begin
         switch_supply_under_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      case (dp_addr)
         ADDR_CFG_A:   rd_mux = {24'h0, 1'b0, code[1], 1'b0, code[0]};
         ADDR_CFG_B:   rd_mux = {24'h0, 1'b0, code[3], 1'b0, code[2]};
         ADDR_DUTY_1:  rd_mux = {24'h0, duty_setting_gen_1};
         ADDR_DUTY_2:  rd_mux = {24'h0, duty_setting_gen_2};
         ADDR_RATE:    rd_mux = {30'h0, generator_rate_select};
         ADDR_TIMER:   rd_mux = {28'h0, timer_duty};
         ADDR_SUPPLY:  rd_mux = {22'h0, switch_supply_under_flag,
                                 switch_supply_over_flag, 5'h0,
                                 supply_fault_recovery,
                                 undervoltage_shutdown_select,
                                 overvoltage_shutdown_select};
         ADDR_OC_STAT: rd_mux = {28'h0, overcurrent_status_reg};
         ADDR_OL_STAT: rd_mux = {28'h0, open_load_status_reg};
         default:      rd_mux = 32'h0;
      endcase
   end
   assign hrdata = dp_read ? rd_mux : 32'h0;
endmodule // high_side_switch_control

// ### design/hs_switch_pkg.sv
// Operation
// - Output sources: direct code, timer, PWM
// - Stop/sleep keep configuration, ignore configuration writes
// - Restart or fail-safe disables all outputs
// - Host re-enables outputs after failure clears
// - Over-voltage forces outputs off unless disabled
// - Under-voltage forces outputs off unless disabled
// - Recovery bit set: return to programmed state
// - Recovery bit clear: stay off, clear codes
// - Supply fault sets only its own flag
// - Filtered over-current switches output off
// - Over-current filter time is 16 us
// - Over-current sets that output's status bit
// - Over-current resets output code to 000
// - Over-current bits stay until host clears
// - Open load checked only while on
// - Open load keeps output on, sticky bit
// - Protections stay active in stop and sleep
// - Two generators with 8-bit duty registers
// - Each generator selects 200 Hz or 400 Hz
// - Assign timer/PWM; PWM starts on write
package hs_switch_pkg;
   localparam int          NUM_OUT        = 4;
   localparam int          CLK_HZ         = 200_000_000;
   localparam int          FILTER_NS      = 16_000;
   localparam int          FILTER_CYC     = (FILTER_NS * (CLK_HZ / 1_000_000)
                                             + 999) / 1000;
   localparam int          TICK_400_CYC   = CLK_HZ / (400 * 256);
   localparam int          TICK_200_CYC   = CLK_HZ / (200 * 256);
   localparam int          TIMER_CYC      = 100_000_000;
   localparam logic [11:0] ADDR_CFG_A     = 12'h000;
   localparam logic [11:0] ADDR_CFG_B     = 12'h004;
   localparam logic [11:0] ADDR_DUTY_1    = 12'h008;
   localparam logic [11:0] ADDR_DUTY_2    = 12'h00c;
   localparam logic [11:0] ADDR_RATE      = 12'h010;
   localparam logic [11:0] ADDR_SUPPLY    = 12'h014;
   localparam logic [11:0] ADDR_OC_STAT   = 12'h018;
   localparam logic [11:0] ADDR_OL_STAT   = 12'h01c;
   localparam logic [11:0] ADDR_TIMER     = 12'h020;
   localparam int          SUP_OV_SEL_BIT = 0;
   localparam int          SUP_UV_SEL_BIT = 1;
   localparam int          SUP_REC_BIT    = 2;
   localparam int          SUP_OV_FLAG    = 8;
   localparam int          SUP_UV_FLAG    = 9;
   typedef enum logic [2:0] {
      CODE_OFF = 3'h0, CODE_ON = 3'h1, CODE_TMR1 = 3'h2, CODE_TMR2 = 3'h3,
      CODE_PWM1 = 3'h4, CODE_PWM2 = 3'h5
   } switch_code_t;
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h0, MODE_STOP = 3'h1, MODE_SLEEP = 3'h3,
      MODE_RESTART = 3'h2, MODE_FAILSAFE = 3'h6
   } chip_mode_t;
endpackage

// ### design/pwm_gen.sv
`timescale 1ns/100ps
module pwm_gen (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Setting
   input  wire logic [7:0] duty,
   input  wire logic       rate_400,
   // Output
   output logic            pwm_out
);
   import hs_switch_pkg::*;
   logic [15:0] div;
   logic [7:0]  phase;
   logic        tick;
   // Per-step enable pulse
   assign tick = (div == 16'((rate_400 ? TICK_400_CYC : TICK_200_CYC) - 1));
   always_ff @(posedge clk) begin
      if (rst || tick) begin
         div <= 16'h0000;
      end else begin
         div <= div + 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= 8'h00;
      end else if (tick) begin
         phase <= phase + 8'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= (phase < duty);
      end
   end
endmodule // pwm_gen

// ### design/oc_filter.sv
`timescale 1ns/100ps
module oc_filter (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Sense
   input  wire logic active,
   input  wire logic over,
   // Result
   output logic      trip
);
   import hs_switch_pkg::*;
   logic [12:0] cnt;
   always_ff @(posedge clk) begin
      if (rst || !active || !over) begin
         cnt <= 13'h0000;
         trip <= 1'b0;
      end else if (cnt == 13'(FILTER_CYC)) begin
         trip <= 1'b1;
      end else begin
         cnt <= cnt + 13'h0001;
         trip <= 1'b0;
      end
   end
endmodule // oc_filter

// ### verification/hs_switch_properties.sv
`timescale 1ns/100ps
module hs_switch_properties (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      rst,
   // Bus
   input wire logic                      hsel,
   input wire logic [31:0]               haddr,
   input wire logic [1:0]                htrans,
   input wire logic                      hwrite,
   input wire logic [31:0]               hwdata,
   input wire logic                      hready,
   // Mode and sense
   input wire hs_switch_pkg::chip_mode_t chip_mode,
   input wire logic                      supply_over,
   input wire logic                      supply_under,
   input wire logic [3:0]                load_over_current,
   // Drive
   input wire logic [3:0]                switched_output
);
   import hs_switch_pkg::*;
   localparam logic [15:0] OC_HI = 16'(FILTER_CYC + 4);
   localparam logic [15:0] OC_LO = 16'(FILTER_CYC - 8);
   logic        ph_wr;
   logic [11:0] ph_addr;
   logic        ov_dis;
   logic        uv_dis;
   logic        rec;
   logic [15:0] oc_cnt;
   logic        wr_dp;
   logic        hold_mode;
   assign wr_dp = ph_wr && chip_mode == MODE_NORMAL;
   assign hold_mode = chip_mode == MODE_RESTART
                      || chip_mode == MODE_FAILSAFE;
   // ----------------------------------------------------------------
   // Shadow of bus writes and over-current run length
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      ph_wr <= !rst && hsel && htrans[1] && hready && hwrite;
      ph_addr <= haddr[11:0];
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         {rec, uv_dis, ov_dis} <= 3'h0;
      end else if (wr_dp && ph_addr == ADDR_SUPPLY) begin
         {rec, uv_dis, ov_dis} <= hwdata[2:0];
      end
   end
   always_ff @(posedge clk) begin
      if (rst || !(switched_output[0] && load_over_current[0])) begin
         oc_cnt <= 16'h0;
      end else begin
         oc_cnt <= oc_cnt + 16'h1;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   restart_off_a: assert property (hold_mode [*3]
      |-> switched_output == 4'h0) else $error("output on in restart");
   host_rearm_a: assert property (($past(chip_mode) == MODE_RESTART
      || $past(chip_mode) == MODE_FAILSAFE) && chip_mode == MODE_NORMAL
      |=> (switched_output == 4'h0) [*2]) else $error("output self on");
   ov_off_a: assert property ((supply_over && !ov_dis) [*3]
      |-> switched_output == 4'h0) else $error("on in over-voltage");
   uv_off_a: assert property ((supply_under && !uv_dis) [*3]
      |-> switched_output == 4'h0) else $error("on in under-voltage");
   no_recover_a: assert property ($fell(supply_over) && !ov_dis
      && !supply_under && !rec |-> (switched_output == 4'h0) [*2])
      else $error("output back without recovery");
   direct_on_a: assert property (wr_dp && ph_addr == ADDR_CFG_A
      && hwdata[2:0] == CODE_ON && !supply_over && !supply_under
      && !load_over_current[0] |-> ##2 switched_output[0])
      else $error("direct on code ignored");
   oc_bound_a: assert property (oc_cnt <= OC_HI)
      else $error("over-current not switched off");
   oc_latch_a: assert property ($fell(switched_output[0])
      && oc_cnt > OC_LO |-> (!switched_output[0]) [*8])
      else $error("output back after over-current");
endmodule // hs_switch_properties

bind high_side_switch_control hs_switch_properties i_props (
   .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .chip_mode(chip_mode), .supply_over(supply_over),
   .supply_under(supply_under), .load_over_current(load_over_current),
   .switched_output(switched_output));

// ### verification/ahb_host_model.sv
`timescale 1ns/100ps
module ahb_host_model (
   // Clock and bus answer
   input  wire logic        clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // Bus request
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   logic [31:0] rdata_q;
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
   end
   always @(posedge clk) rdata_q <= hrdata;
   // Single word transfers, one at a time
   task automatic xfer(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      hwdata <= ~d;
      #1;
      q = rdata_q;
   endtask
endmodule // ahb_host_model

// ### verification/high_side_switch_control_test.sv
`timescale 1ns/100ps
module high_side_switch_control_test;
   import hs_switch_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel, hwrite, hready, hresp, so, su;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [3:0] oc, ol, sw;
   chip_mode_t md;
   int mismatches = 0;
   int compares = 0;
   int h, i;
   always #2.5 clk = ~clk;
   ahb_host_model i_host (.clk(clk), .hready(hready), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));
   high_side_switch_control #(.TIMER_PERIOD(64)) i_dut (.clk(clk),
      .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .chip_mode(md),
      .supply_over(so), .supply_under(su), .load_over_current(oc),
      .load_open(ol), .switched_output(sw));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_host.xfer(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      i_host.xfer(a, 1'b0, 32'h0, q);
      chk(q, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic out(input logic [3:0] e);
      chk({28'h0, sw}, {28'h0, e});
   endtask
   task automatic hi(input int n, input int b);
      h = 0;
      repeat (n) begin
         cyc(1);
         h += int'(sw[b] === 1'b1);
      end
   endtask
   task automatic close_out;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      close_out();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      md = MODE_NORMAL;
      {so, su, oc, ol} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      out(4'h0);
      chk({30'h0, hready, hresp}, 32'h2);
      wr(ADDR_CFG_A, 32'h11);
      cyc(2);
      out(4'h3);
      rd(ADDR_CFG_A, 32'h11);
      wr(12'h030, 32'hffffffff);
      rd(12'h030, 32'h0);
      for (i = 0; i < 2; i++) begin
         @(posedge clk) md <= i ? MODE_SLEEP : MODE_STOP;
         wr(ADDR_CFG_A, 32'h0);
         cyc(2);
         out(4'h3);
         rd(ADDR_CFG_A, 32'h11);
      end
      @(posedge clk) so <= 1'b1;
      cyc(4);
      out(4'h0);
      rd(ADDR_SUPPLY, 32'h100);
      rd(ADDR_OC_STAT, 32'h0);
      @(posedge clk) so <= 1'b0;
      cyc(4);
      out(4'h0);
      @(posedge clk) md <= MODE_NORMAL;
      rd(ADDR_CFG_A, 32'h0);
      wr(ADDR_SUPPLY, 32'h104);
      wr(ADDR_CFG_A, 32'h11);
      @(posedge clk) su <= 1'b1;
      cyc(4);
      out(4'h0);
      @(posedge clk) su <= 1'b0;
      cyc(4);
      out(4'h3);
      for (i = 0; i < 2; i++) begin
         wr(ADDR_SUPPLY, 32'h304 | (1 << i));
         @(posedge clk) {su, so} <= 2'(1 << i);
         cyc(4);
         out(4'h3);
         rd(ADDR_SUPPLY, 32'h4 | (32'h101 << i));
         @(posedge clk) {su, so} <= 2'h0;
      end
      wr(ADDR_SUPPLY, 32'h304);
      @(posedge clk) oc <= 4'h1;
      cyc(FILTER_CYC - 20);
      @(posedge clk) oc <= 4'h0;
      cyc(2);
      out(4'h3);
      @(posedge clk) oc <= 4'h1;
      cyc(FILTER_CYC + 20);
      out(4'h2);
      rd(ADDR_OC_STAT, 32'h1);
      rd(ADDR_CFG_A, 32'h10);
      @(posedge clk) oc <= 4'h0;
      cyc(20);
      rd(ADDR_OC_STAT, 32'h1);
      wr(ADDR_OC_STAT, 32'h1);
      rd(ADDR_OC_STAT, 32'h0);
      wr(ADDR_CFG_A, 32'h11);
      cyc(2);
      out(4'h3);
      @(posedge clk) ol <= 4'h6;
      cyc(4);
      out(4'h3);
      rd(ADDR_OL_STAT, 32'h2);
      @(posedge clk) ol <= 4'h0;
      rd(ADDR_OL_STAT, 32'h2);
      wr(ADDR_OL_STAT, 32'h2);
      rd(ADDR_OL_STAT, 32'h0);
      wr(ADDR_CFG_B, 32'h20);
      hi(128, 3);
      chk(32'(h), 32'd64);
      wr(ADDR_TIMER, 32'h4);
      rd(ADDR_TIMER, 32'h4);
      wr(ADDR_CFG_B, 32'h30);
      hi(128, 3);
      chk(32'(h), 32'd32);
      wr(ADDR_RATE, 32'h1);
      wr(ADDR_DUTY_1, 32'h0);
      wr(ADDR_DUTY_2, 32'hff);
      wr(ADDR_CFG_B, 32'h54);
      hi(4000, 2);
      chk(32'(h), 32'd0);
      hi(8000, 3);
      chk(32'(h > 4000), 32'd1);
      @(posedge clk) md <= MODE_RESTART;
      cyc(4);
      out(4'h0);
      @(posedge clk) md <= MODE_FAILSAFE;
      cyc(4);
      out(4'h0);
      @(posedge clk) md <= MODE_NORMAL;
      cyc(4);
      out(4'h0);
      wr(ADDR_CFG_A, 32'h11);
      cyc(2);
      out(4'h3);
      close_out();
   end
endmodule // high_side_switch_control_test
